// >>> common/psc_pkg.sv
package psc_pkg;
	// register map: printed offset 0x4003 is not a multiple of four, so it is an index
	localparam logic [15:0] PSC_IDX_POWER_STATE = 16'h4003;
	localparam logic [15:0] PSC_IDX_IRQ_STATUS = 16'h4010;
	localparam logic [15:0] PSC_IDX_IRQ_MASK = 16'h4011;
	localparam logic [17:0] PSC_ADDR_POWER_STATE = {PSC_IDX_POWER_STATE, 2'b00};
	localparam logic [17:0] PSC_ADDR_IRQ_STATUS = {PSC_IDX_IRQ_STATUS, 2'b00};
	localparam logic [17:0] PSC_ADDR_IRQ_MASK = {PSC_IDX_IRQ_MASK, 2'b00};
	// field positions
	localparam int PSC_BIT_ON = 15;
	localparam int PSC_BIT_SLP = 14;
	localparam int PSC_BIT_LOW_POWER_REFERENCE_SELECT = 12;
	localparam int PSC_DLY_HI = 11;
	localparam int PSC_DLY_LO = 10;
	localparam int PSC_BIT_RST_DLY = 9;
	localparam int PSC_POL_HI = 5;
	localparam int PSC_POL_LO = 4;
	localparam int PSC_BIT_LIM_STS = 3;
	localparam int PSC_LIM_HI = 2;
	localparam int PSC_LIM_LO = 0;
	// reset values
	localparam logic [1:0] PSC_DLY_RST = 2'h2;
	localparam logic [2:0] PSC_LIM_RST = 3'h2;
	localparam logic [1:0] PSC_POL_RST = 2'h0;
	// codes
	localparam logic [2:0] PSC_LIM_100MA = 3'h2;
	localparam logic [2:0] PSC_LIM_UNDEF = 3'h6;
	localparam logic [1:0] PSC_DLY_1MS = 2'h2;
	localparam logic [1:0] PSC_DLY_10MS = 2'h3;
	localparam logic [1:0] PSC_POL_SOFT = 2'h1;
	localparam logic [1:0] PSC_POL_3V1 = 2'h2;
	localparam logic [1:0] PSC_POL_3V4 = 2'h3;
	// timing: 200 MHz clock
	localparam int PSC_CLK_MHZ = 200;
	localparam int PSC_DLY_1MS_US = 1000;
	localparam int PSC_DLY_10MS_US = 10000;
	localparam int PSC_CYC_1MS = PSC_DLY_1MS_US * PSC_CLK_MHZ;
	localparam int PSC_CYC_10MS = PSC_DLY_10MS_US * PSC_CLK_MHZ;
	// interrupt bits
	localparam int PSC_IRQ_N = 5;
	localparam int PSC_IRQ_OFF = 0;
	localparam int PSC_IRQ_SLEEP = 1;
	localparam int PSC_IRQ_WAKE = 2;
	localparam int PSC_IRQ_RST = 3;
	localparam int PSC_IRQ_LIM = 4;
	typedef enum logic [1:0] {
		PSC_ST_OFF, PSC_ST_ON, PSC_ST_SLEEP
	} psc_state_t;
endpackage

// >>> rtl/psc_power_state_control.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - bit 15 reads 0 when off, 1 when on or asleep
// - writing 0 to bit 15 starts an OFF transition
// - writing 1 to bit 15 never starts an ON transition
// - bit 14 reads 1 while in SLEEP, else 0
// - writing bit 14 as 0 commands WAKE, as 1 commands SLEEP
// - bit 12 selects normal (0) or low-power (1) voltage reference
// - delay field: 00/01 none, 10 one ms, 11 ten ms on transitions
// - reset-delay bit postpones software reset by transition delay
// - start-up policy applies only on USB power with limit code 010
// - policy: normal, soft-start, battery above 3.1 V, battery above 3.4 V
// - gated start below threshold enables trickle and holds request pending
// - bit 3 reads 1 while USB input current limit is reached
// - limit field selects 0, 2.5, 100, 500, 900, 1500, 550 mA
module psc_power_state_control
	import psc_pkg::*;
#(
	parameter int CYC_1MS = PSC_CYC_1MS,
	parameter int CYC_10MS = PSC_CYC_10MS
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// power events and analogue status
	input wire logic on_request,
	input wire logic soft_reset_request,
	input wire logic usb_supply_rail,
	input wire logic battery_above_3v1,
	input wire logic battery_above_3v4,
	input wire logic usb_limit_reached,
	// controls to the power domain
	output logic system_on,
	output logic system_sleep,
	output logic low_power_reference_select,
	output logic [2:0] usb_input_current_limit,
	output logic soft_start_enable,
	output logic trickle_charge_enable,
	output logic soft_reset_out,
	output logic irq
);
	psc_state_t state_q;
	logic [1:0] transition_delay_select_q;
	logic soft_reset_delay_enable_q, usb_limit_reached_flag_q;
	logic [1:0] low_current_usb_startup_policy_q;
	logic [PSC_IRQ_N-1:0] irq_sts_q, irq_mask_q, irq_evt;
	logic [23:0] dly_cnt_q, dly_cyc, rst_cnt_q;
	logic [1:0] pend_q; // 0 none, 1 off, 2 sleep, 3 wake
	logic start_pend_q, rst_pend_q, start_go, lim_q;
	logic wr, rd_sel, ps_wr, st_wr, mk_wr, pol_active, batt_ok;
	logic [15:0] ps_rd;

	// one wait-free apb access: answer in the first access cycle
	assign wr = psel && penable && pwrite;
	assign rd_sel = psel && !penable && !pwrite;
	assign ps_wr = wr && paddr[17:0] == PSC_ADDR_POWER_STATE && &pstrb[1:0];
	assign st_wr = wr && paddr[17:0] == PSC_ADDR_IRQ_STATUS && pstrb[0];
	assign mk_wr = wr && paddr[17:0] == PSC_ADDR_IRQ_MASK && pstrb[0];

	// delay length from code, 00 and 01 give no delay
	always_comb begin
		unique case (transition_delay_select_q)
			PSC_DLY_1MS: dly_cyc = 24'(CYC_1MS);
			PSC_DLY_10MS: dly_cyc = 24'(CYC_10MS);
			default: dly_cyc = 24'h00_0000;
		endcase
	end

	// readback view; unlisted bits are zero
	always_comb begin
		ps_rd = 16'h0000;
		ps_rd[PSC_BIT_ON] = state_q != PSC_ST_OFF;
		ps_rd[PSC_BIT_SLP] = state_q == PSC_ST_SLEEP;
		ps_rd[PSC_BIT_LOW_POWER_REFERENCE_SELECT] = low_power_reference_select;
		ps_rd[PSC_DLY_HI:PSC_DLY_LO] = transition_delay_select_q;
		ps_rd[PSC_BIT_RST_DLY] = soft_reset_delay_enable_q;
		ps_rd[PSC_POL_HI:PSC_POL_LO] = low_current_usb_startup_policy_q;
		ps_rd[PSC_BIT_LIM_STS] = usb_limit_reached_flag_q;
		ps_rd[PSC_LIM_HI:PSC_LIM_LO] = usb_input_current_limit;
	end

	// bus answer registered in setup so it stands in the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable
				&& paddr[17:0] != PSC_ADDR_POWER_STATE
				&& paddr[17:0] != PSC_ADDR_IRQ_STATUS
				&& paddr[17:0] != PSC_ADDR_IRQ_MASK;
			prdata <= 32'h0000_0000;
			if (rd_sel) begin
				if (paddr[17:0] == PSC_ADDR_POWER_STATE)
					prdata <= {16'h0000, ps_rd};
				else if (paddr[17:0] == PSC_ADDR_IRQ_STATUS)
					prdata <= {27'h0, irq_sts_q};
				else if (paddr[17:0] == PSC_ADDR_IRQ_MASK)
					prdata <= {27'h0, irq_mask_q};
			end
		end
	end

	// software configuration fields
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_power_reference_select <= 1'b0;
			transition_delay_select_q <= PSC_DLY_RST;
			soft_reset_delay_enable_q <= 1'b0;
			low_current_usb_startup_policy_q <= PSC_POL_RST;
			usb_input_current_limit <= PSC_LIM_RST;
		end else if (ps_wr) begin
			low_power_reference_select <= pwdata[PSC_BIT_LOW_POWER_REFERENCE_SELECT];
			transition_delay_select_q <= pwdata[PSC_DLY_HI:PSC_DLY_LO];
			soft_reset_delay_enable_q <= pwdata[PSC_BIT_RST_DLY];
			low_current_usb_startup_policy_q <= pwdata[PSC_POL_HI:PSC_POL_LO];
			// undefined code is refused, limit keeps its value
			if (pwdata[PSC_LIM_HI:PSC_LIM_LO] != PSC_LIM_UNDEF)
				usb_input_current_limit <= pwdata[PSC_LIM_HI:PSC_LIM_LO];
		end
	end

	// start-up policy under low-current usb power
	assign pol_active = usb_supply_rail
		&& usb_input_current_limit == PSC_LIM_100MA;
	assign batt_ok = !pol_active
		|| (low_current_usb_startup_policy_q == PSC_POL_3V1 ? battery_above_3v1
		: low_current_usb_startup_policy_q == PSC_POL_3V4 ? battery_above_3v4
		: 1'b1);
	assign start_go = start_pend_q && batt_ok && state_q == PSC_ST_OFF;

	// pending start-up request, trickle charge while held
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_pend_q <= 1'b0;
			trickle_charge_enable <= 1'b0;
			soft_start_enable <= 1'b0;
		end else begin
			if (on_request && state_q == PSC_ST_OFF)
				start_pend_q <= 1'b1;
			else if (start_go || state_q != PSC_ST_OFF)
				start_pend_q <= 1'b0;
			trickle_charge_enable <= start_pend_q && !batt_ok;
			soft_start_enable <= pol_active
				&& low_current_usb_startup_policy_q == PSC_POL_SOFT;
		end
	end

	// power state machine; software write to on bit only turns off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= PSC_ST_OFF;
			pend_q <= 2'h0;
			dly_cnt_q <= 24'h00_0000;
		end else if (pend_q != 2'h0) begin
			if (dly_cnt_q != 24'h00_0000)
				dly_cnt_q <= dly_cnt_q - 24'h00_0001;
			else begin
				pend_q <= 2'h0;
				unique case (pend_q)
					2'h1: state_q <= PSC_ST_OFF;
					2'h2: state_q <= PSC_ST_SLEEP;
					default: state_q <= PSC_ST_ON;
				endcase
			end
		end else if (ps_wr && state_q != PSC_ST_OFF
			&& !pwdata[PSC_BIT_ON]) begin
			pend_q <= 2'h1;
			dly_cnt_q <= dly_cyc;
		end else if (ps_wr && state_q == PSC_ST_ON && pwdata[PSC_BIT_SLP]) begin
			pend_q <= 2'h2;
			dly_cnt_q <= dly_cyc;
		end else if (ps_wr && state_q == PSC_ST_SLEEP
			&& !pwdata[PSC_BIT_SLP]) begin
			pend_q <= 2'h3;
			dly_cnt_q <= dly_cyc;
		end else if (start_go) begin
			// only a hardware on request powers up, never a write of one
			pend_q <= 2'h3;
			dly_cnt_q <= dly_cyc;
		end
	end

	// software reset, optionally postponed by the transition delay
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rst_pend_q <= 1'b0;
			rst_cnt_q <= 24'h00_0000;
			soft_reset_out <= 1'b0;
		end else begin
			soft_reset_out <= 1'b0;
			if (soft_reset_request && !rst_pend_q) begin
				if (soft_reset_delay_enable_q && dly_cyc != 24'h00_0000) begin
					rst_pend_q <= 1'b1;
					rst_cnt_q <= dly_cyc - 24'h00_0001;
				end else
					soft_reset_out <= 1'b1;
			end else if (rst_pend_q) begin
				if (rst_cnt_q == 24'h00_0000) begin
					rst_pend_q <= 1'b0;
					soft_reset_out <= 1'b1;
				end else
					rst_cnt_q <= rst_cnt_q - 24'h00_0001;
			end
		end
	end

	// limit status follows input; edge raises an event
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			usb_limit_reached_flag_q <= 1'b0;
			lim_q <= 1'b0;
		end else begin
			usb_limit_reached_flag_q <= usb_limit_reached;
			lim_q <= usb_limit_reached;
		end
	end

	assign irq_evt[PSC_IRQ_OFF] = pend_q == 2'h1 && dly_cnt_q == 24'h0 ;
	assign irq_evt[PSC_IRQ_SLEEP] = pend_q == 2'h2 && dly_cnt_q == 24'h0;
	assign irq_evt[PSC_IRQ_WAKE] = pend_q == 2'h3 && dly_cnt_q == 24'h0;
	assign irq_evt[PSC_IRQ_RST] = soft_reset_out;
	assign irq_evt[PSC_IRQ_LIM] = usb_limit_reached && !lim_q;

	// sticky status, write one clears; a new event wins over the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_sts_q <= '0;
			irq_mask_q <= '0;
			irq <= 1'b0;
		end else begin
			irq_sts_q <= (irq_sts_q & ~(st_wr ? pwdata[PSC_IRQ_N-1:0] : '0))
				| irq_evt;
			if (mk_wr)
				irq_mask_q <= pwdata[PSC_IRQ_N-1:0];
			irq <= |(irq_sts_q & irq_mask_q);
		end
	end

	// state outputs straight from flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			system_on <= 1'b0;
			system_sleep <= 1'b0;
		end else begin
			system_on <= state_q != PSC_ST_OFF;
			system_sleep <= state_q == PSC_ST_SLEEP;
		end
	end

	// checks
	sequence s_off_write;
		ps_wr && state_q != PSC_ST_OFF && pend_q == 2'h0 && !pwdata[PSC_BIT_ON];
	endsequence
	property p_off_cmd;
		@(posedge pclk) disable iff (!presetn) s_off_write |=> pend_q == 2'h1;
	endproperty
	a_off_cmd: assert property (p_off_cmd) else $error("off write ignored");
	property p_no_sw_on;
		@(posedge pclk) disable iff (!presetn)
		state_q == PSC_ST_OFF && !start_go && pend_q == 2'h0 |=> state_q == PSC_ST_OFF;
	endproperty
	a_no_sw_on: assert property (p_no_sw_on) else $error("spurious power on");
	// a power register read: setup, then the answered access cycle
	sequence s_ps_read;
		rd_sel && paddr[17:0] == PSC_ADDR_POWER_STATE ##1 pready;
	endsequence
	property p_on_bit;
		@(posedge pclk) disable iff (!presetn)
		s_ps_read |-> prdata[PSC_BIT_ON] == system_on;
	endproperty
	a_on_bit: assert property (p_on_bit) else $error("on bit wrong");
	property p_slp_bit;
		@(posedge pclk) disable iff (!presetn)
		s_ps_read |-> prdata[PSC_BIT_SLP] == system_sleep;
	endproperty
	a_slp_bit: assert property (p_slp_bit) else $error("sleep bit wrong");
	property p_delay_none;
		@(posedge pclk) disable iff (!presetn)
		s_off_write and !transition_delay_select_q[1]
		|=> ##1 state_q == PSC_ST_OFF;
	endproperty
	a_delay_none: assert property (p_delay_none) else $error("delay inserted");
	property p_rst_nodly;
		@(posedge pclk) disable iff (!presetn)
		soft_reset_request && !rst_pend_q && !soft_reset_delay_enable_q
		|=> soft_reset_out;
	endproperty
	a_rst_nodly: assert property (p_rst_nodly) else $error("reset late");
	property p_trickle;
		@(posedge pclk) disable iff (!presetn)
		start_pend_q && !batt_ok |=> trickle_charge_enable;
	endproperty
	a_trickle: assert property (p_trickle) else $error("no trickle");
	property p_lim_undef;
		@(posedge pclk) disable iff (!presetn)
		usb_input_current_limit != PSC_LIM_UNDEF;
	endproperty
	a_lim_undef: assert property (p_lim_undef) else $error("undefined limit");
	property p_lim_sts;
		@(posedge pclk) disable iff (!presetn)
		usb_limit_reached |=> ps_rd[PSC_BIT_LIM_STS];
	endproperty
	a_lim_sts: assert property (p_lim_sts) else $error("limit flag missed");
endmodule
`default_nettype wire

// >>> test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import psc_pkg::*;
;
	localparam int C1 = 20;
	localparam int C10 = 50;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [31:0] paddr, pwdata, prdata, rdat;
	logic [3:0] pstrb;
	logic on_request, soft_reset_request, usb_supply_rail;
	logic battery_above_3v1, battery_above_3v4, usb_limit_reached;
	logic system_on, system_sleep, low_power_reference_select;
	logic [2:0] usb_input_current_limit;
	logic soft_start_enable, trickle_charge_enable, soft_reset_out, irq;
	logic last_err;
	int error_cnt, comparisons, n;
	// shortened delay counts keep the run small
	psc_power_state_control #(.CYC_1MS(C1), .CYC_10MS(C10))
		psc_power_state_control_inst (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .on_request(on_request),
		.soft_reset_request(soft_reset_request),
		.usb_supply_rail(usb_supply_rail),
		.battery_above_3v1(battery_above_3v1),
		.battery_above_3v4(battery_above_3v4),
		.usb_limit_reached(usb_limit_reached), .system_on(system_on),
		.system_sleep(system_sleep),
		.low_power_reference_select(low_power_reference_select),
		.usb_input_current_limit(usb_input_current_limit),
		.soft_start_enable(soft_start_enable),
		.trickle_charge_enable(trickle_charge_enable),
		.soft_reset_out(soft_reset_out), .irq(irq));
	// clock at 5 ns period
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
		input string msg);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: %s got %h want %h", $time, msg,
				seen, exp);
		end
	endtask
	task automatic wrap_up();
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// one apb transfer; holds the request until pready is sampled high
	task automatic apb(input logic w, input logic [31:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// only the watchdog ends a wait for the answer
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdat = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [31:0] a, input logic [15:0] d);
		apb(1'b1, a, {16'h0000, d});
	endtask
	task automatic rd(input logic [31:0] a, input logic [15:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(rdat, {16'h0000, exp}, "read data");
	endtask
	task automatic wt(input int c);
		repeat (c) @(posedge pclk);
	endtask
	// bounded wait for a power state
	task automatic wst(input logic on_w, input logic slp_w, input int c);
		n = 0;
		while ((system_on !== on_w || system_sleep !== slp_w) && n < c) begin
			@(posedge pclk);
			n++;
		end
		chk({system_on, system_sleep}, {on_w, slp_w}, "state");
	endtask
	task automatic pulse_on();
		on_request <= 1'b1;
		@(posedge pclk);
		on_request <= 1'b0;
	endtask
	// reset contents, then on, sleep, wake and delayed off
	task automatic t_states();
		rd(32'(PSC_ADDR_POWER_STATE), 16'h0802);
		chk(usb_input_current_limit, 3'h2, "limit");
		pulse_on();
		wst(1'b1, 1'b0, 200);
		rd(32'(PSC_ADDR_POWER_STATE), 16'h8802);
		wr(32'(PSC_ADDR_POWER_STATE), 16'hC802);
		wst(1'b1, 1'b1, 200);
		rd(32'(PSC_ADDR_POWER_STATE), 16'hC802);
		wr(32'(PSC_ADDR_POWER_STATE), 16'h8802);
		wst(1'b1, 1'b0, 200);
		wr(32'(PSC_ADDR_POWER_STATE), 16'h0802);
		wt(C1 / 2);
		chk(system_on, 1'b1, "off too early");
		wst(1'b0, 1'b0, 3 * C1);
		rd(32'(PSC_ADDR_POWER_STATE), 16'h0802);
		wr(32'(PSC_ADDR_POWER_STATE), 16'h8802);
		wt(3 * C1);
		chk(system_on, 1'b0, "write one powered on");
	endtask
	// field writes: undefined limit code, unlisted bits, reference
	task automatic t_fields();
		wr(32'(PSC_ADDR_POWER_STATE), 16'h0806);
		rd(32'(PSC_ADDR_POWER_STATE), 16'h0802);
		// no auxiliary converter in this bench, so low-power reference is fine
		wr(32'(PSC_ADDR_POWER_STATE), 16'h3005);
		rd(32'(PSC_ADDR_POWER_STATE), 16'h1005);
		chk(low_power_reference_select, 1'b1, "ref");
		chk(usb_input_current_limit, 3'h5, "limit");
		apb(1'b0, 32'h0000_0100, 32'h0000_0000);
		chk(last_err, 1'b1, "unmapped");
	endtask
	// software reset with and without the postponement
	task automatic t_reset(input logic [15:0] v, input int lo, input int hi);
		wr(32'(PSC_ADDR_POWER_STATE), v);
		soft_reset_request <= 1'b1;
		@(posedge pclk);
		soft_reset_request <= 1'b0;
		n = 0;
		while (soft_reset_out !== 1'b1 && n < hi) begin
			@(posedge pclk);
			n++;
		end
		chk(n >= lo && n < hi, 1'b1, "reset timing");
		wt(2);
	endtask
	// battery gated start under low-current usb power
	task automatic t_gate();
		// limit at 100 mA before the usb supply starts the device
		wr(32'(PSC_ADDR_POWER_STATE), 16'h0022);
		usb_supply_rail <= 1'b1;
		pulse_on();
		wt(10);
		chk({system_on, trickle_charge_enable}, 2'b01, "gated");
		battery_above_3v1 <= 1'b1;
		wst(1'b1, 1'b0, 50);
		chk(trickle_charge_enable, 1'b0, "trickle");
		wr(32'(PSC_ADDR_POWER_STATE), 16'h0022);
		wst(1'b0, 1'b0, 50);
		// soft-start policy, then a limit code outside the policy
		wr(32'(PSC_ADDR_POWER_STATE), 16'h0012);
		wt(2);
		chk(soft_start_enable, 1'b1, "soft start");
		wr(32'(PSC_ADDR_POWER_STATE), 16'h0013);
		wt(2);
		chk(soft_start_enable, 1'b0, "policy off");
		// higher battery threshold holds the start until it is met
		wr(32'(PSC_ADDR_POWER_STATE), 16'h0032);
		pulse_on();
		wt(10);
		chk({system_on, trickle_charge_enable}, 2'b01, "gated 3v4");
		battery_above_3v4 <= 1'b1;
		wst(1'b1, 1'b0, 50);
		chk(trickle_charge_enable, 1'b0, "trickle 3v4");
		wr(32'(PSC_ADDR_POWER_STATE), 16'h0032);
		wst(1'b0, 1'b0, 50);
	endtask
	// limit flag and interrupt raise, mask and clear
	task automatic t_irq();
		rd(32'(PSC_ADDR_IRQ_STATUS), 16'h000F);
		wr(32'(PSC_ADDR_IRQ_STATUS), 16'h001F);
		usb_limit_reached <= 1'b1;
		wt(3);
		chk(irq, 1'b0, "masked irq");
		rd(32'(PSC_ADDR_IRQ_STATUS), 16'h0010);
		rd(32'(PSC_ADDR_POWER_STATE), 16'h003A);
		wr(32'(PSC_ADDR_IRQ_MASK), 16'h0010);
		wt(2);
		chk(irq, 1'b1, "irq");
		wr(32'(PSC_ADDR_IRQ_STATUS), 16'h0010);
		wt(2);
		chk(irq, 1'b0, "irq clear");
	endtask
	// watchdog on the whole run
	initial begin
		#100000;
		error_cnt++;
		wrap_up();
	end
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, on_request, soft_reset_request} = 5'h00;
		{usb_supply_rail, battery_above_3v1, battery_above_3v4} = 3'h0;
		usb_limit_reached = 1'b0;
		paddr = 32'h0000_0000;
		pwdata = 32'h0000_0000;
		pstrb = 4'hF;
		error_cnt = 0;
		comparisons = 0;
		wt(10);
		presetn <= 1'b1;
		@(posedge pclk);
		t_states();
		t_fields();
		t_reset(16'h0E02, C10 - 5, C10 + 20);
		t_reset(16'h0C02, 0, 4);
		t_gate();
		t_irq();
		wrap_up();
	end
endmodule
`default_nettype wire
